// file: osmc_pkg.sv
// Operation
// - Squelch-enabled channel is disabled while the source is invalid.
// - Channel with squelch disabled keeps running whatever the source state.
// - One read-write squelch bit per channel, bit n for channel n, reset 1.
// - Aux pin carrying a clock with squelch set is off on invalid source.
// - Aux pin not carrying a clock ignores its squelch bit, keeps running.
// - Aux pin with squelch bit 0 keeps running whatever the source state.
// - Aux pin 1 squelch at bit 1 reset 1; aux pin 0 at bit 0 reset 0.
// - Margin delay bit enables margining only for divide values above 8.
// - Bits 5..2 drive dividers 7..4, 1 pair 23, 0 pair 01; all reset 0.
package osmc_pkg;

  // Bus and datapath widths.
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int NUM_CHAN = 8;
  localparam int NUM_AUX  = 2;
  localparam int NUM_DIV  = 6;
  localparam int DIV_W    = 8;

  // Register offsets on the configuration port.
  localparam logic [ADDR_W-1:0] OFFS_CHAN_SQ      = 8'h16;
  localparam logic [ADDR_W-1:0] OFFS_AUX_SQ       = 8'h17;
  localparam logic [ADDR_W-1:0] OFFS_DIV_DLY      = 8'h18;
  localparam logic [ADDR_W-1:0] OFFS_GATE_STATE   = 8'h30;
  localparam logic [ADDR_W-1:0] OFFS_MARGIN_STATE = 8'h31;

  // Reset values and writable-bit masks.
  localparam logic [DATA_W-1:0] RST_CHAN_SQ  = 8'hff;
  localparam logic [DATA_W-1:0] RST_AUX_SQ   = 8'h02;
  localparam logic [DATA_W-1:0] RST_DIV_DLY  = 8'h00;
  localparam logic [DATA_W-1:0] MASK_CHAN_SQ = 8'hff;
  localparam logic [DATA_W-1:0] MASK_AUX_SQ  = 8'h03;
  localparam logic [DATA_W-1:0] MASK_DIV_DLY = 8'h3f;
  localparam logic [DATA_W-1:0] RDATA_IDLE   = 8'h00;

  // Field positions.
  localparam int AUX0_BIT       = 0;
  localparam int AUX1_BIT       = 1;
  localparam int DIV_PAIR01_BIT = 0;
  localparam int DIV_PAIR23_BIT = 1;
  localparam int DIV4_BIT       = 2;
  localparam int DIV5_BIT       = 3;
  localparam int DIV6_BIT       = 4;
  localparam int DIV7_BIT       = 5;

  // Margining needs a divide value strictly above this.
  localparam logic [DIV_W-1:0] DIV_MARGIN_MIN = 8'h08;

  // Decoded register selection.
  typedef enum logic [2:0] {
    OSMC_SEL_NONE,
    OSMC_SEL_CHAN,
    OSMC_SEL_AUX,
    OSMC_SEL_DIV,
    OSMC_SEL_GATE,
    OSMC_SEL_MARGIN
  } osmc_sel_t;

endpackage

// file: osmc_squelch_gate.sv
module osmc_squelch_gate
  import osmc_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] squelch_en,
  input  wire logic [N-1:0] carries_clk,
  input  wire logic         src_invalid,
  output logic      [N-1:0] out_enable_q
);

  // One registered enable per output; all share the same invalid flag.
  for (genvar i = 0; i < N; i++) begin : g_gate
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        out_enable_q[i] <= 1'b1;
      end else begin
        out_enable_q[i] <= !(squelch_en[i] && carries_clk[i]
                             && src_invalid);
      end
    end
  end

endmodule

// file: osmc_output_squelch_margin_ctrl.sv
// Added by the designer: the address-and-strobe port.
module osmc_output_squelch_margin_ctrl
  import osmc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata_q,
  input  wire logic              src_invalid,
  input  wire logic              aux_pin0_clk_mode,
  input  wire logic              aux_pin1_clk_mode,
  input  wire logic [DIV_W-1:0]  div_pair01_ratio,
  input  wire logic [DIV_W-1:0]  div_pair23_ratio,
  input  wire logic [DIV_W-1:0]  div4_ratio,
  input  wire logic [DIV_W-1:0]  div5_ratio,
  input  wire logic [DIV_W-1:0]  div6_ratio,
  input  wire logic [DIV_W-1:0]  div7_ratio,
  output logic      [NUM_CHAN-1:0] chan_enable_q,
  output logic      [NUM_AUX-1:0]  aux_enable_q,
  output logic      [NUM_DIV-1:0]  div_margin_active_q
);

  logic                rst_sync1_q;
  logic                rst_n_q;
  logic                inv_sync1_q;
  logic                inv_q;
  logic [DATA_W-1:0]   chan_sq_q;
  logic [NUM_AUX-1:0]  aux_sq_q;
  logic [NUM_DIV-1:0]  div_dly_q;
  logic [NUM_AUX-1:0]  aux_mode_q;
  logic [NUM_AUX-1:0]  aux_mode_sync_q;
  logic [DIV_W-1:0]    ratio [NUM_DIV];
  logic [NUM_DIV-1:0]  over_min;
  osmc_sel_t           sel;
  logic [DATA_W-1:0]   rd_mux;

  // Reset is asserted at once but released only after two clean edges,
  // so no flop leaves reset on a partial edge.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1_q <= 1'b0;
      rst_n_q     <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n_q     <= rst_sync1_q;
    end
  end

  // The invalid flag comes from detection logic on another timing path.
  // Two flops tame it; only the second is read by the gating.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      inv_sync1_q <= 1'b0;
      inv_q       <= 1'b0;
    end else begin
      inv_sync1_q <= src_invalid;
      inv_q       <= inv_sync1_q;
    end
  end

  // The aux pin modes are static straps, but they come from pins.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aux_mode_sync_q <= '0;
      aux_mode_q      <= '0;
    end else begin
      aux_mode_sync_q <= {aux_pin1_clk_mode, aux_pin0_clk_mode};
      aux_mode_q      <= aux_mode_sync_q;
    end
  end

  // Address decode shared by the write and read paths.
  always_comb begin
    case (reg_addr)
      OFFS_CHAN_SQ:      sel = OSMC_SEL_CHAN;
      OFFS_AUX_SQ:       sel = OSMC_SEL_AUX;
      OFFS_DIV_DLY:      sel = OSMC_SEL_DIV;
      OFFS_GATE_STATE:   sel = OSMC_SEL_GATE;
      OFFS_MARGIN_STATE: sel = OSMC_SEL_MARGIN;
      default:           sel = OSMC_SEL_NONE;
    endcase
  end

  // Channel squelch enables, one bit per channel.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chan_sq_q <= RST_CHAN_SQ;
    end else if (reg_wr && sel == OSMC_SEL_CHAN) begin
      chan_sq_q <= reg_wdata & MASK_CHAN_SQ;
    end
  end

  // Aux pin squelch enables; upper bits are not stored at all.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aux_sq_q <= RST_AUX_SQ[NUM_AUX-1:0];
    end else if (reg_wr && sel == OSMC_SEL_AUX) begin
      aux_sq_q[AUX1_BIT] <= reg_wdata[AUX1_BIT];
      aux_sq_q[AUX0_BIT] <= reg_wdata[AUX0_BIT];
    end
  end

  // Divider margin delay enables; bits 7 and 6 are dropped.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      div_dly_q <= RST_DIV_DLY[NUM_DIV-1:0];
    end else if (reg_wr && sel == OSMC_SEL_DIV) begin
      div_dly_q <= reg_wdata[NUM_DIV-1:0];
    end
  end

  // Read mux; reserved bits come back as zero, padded above the stored bits.
  always_comb begin
    case (sel)
      OSMC_SEL_CHAN:   rd_mux = chan_sq_q;
      OSMC_SEL_AUX:    rd_mux = {{(DATA_W-NUM_AUX){1'b0}}, aux_sq_q};
      OSMC_SEL_DIV:    rd_mux = {{(DATA_W-NUM_DIV){1'b0}}, div_dly_q};
      OSMC_SEL_GATE:   rd_mux = chan_enable_q;
      OSMC_SEL_MARGIN: rd_mux = {{(DATA_W-NUM_DIV){1'b0}},
                                 div_margin_active_q};
      default:         rd_mux = RDATA_IDLE;
    endcase
  end

  // Read data stand for exactly one cycle after the strobe, else idle.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_q <= RDATA_IDLE;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= RDATA_IDLE;
    end
  end

  // The eight channels always carry a clock, so every one qualifies.
  osmc_squelch_gate #(
    .N (NUM_CHAN)
  ) u_chan_gate (
    .clk          (ref_clk),
    .rst_n        (rst_n_q),
    .squelch_en   (chan_sq_q),
    .carries_clk  ({NUM_CHAN{1'b1}}),
    .src_invalid  (inv_q),
    .out_enable_q (chan_enable_q)
  );

  // Aux pins only squelch while they are set up to carry a clock; as
  // status outputs they must keep reporting during an outage.
  osmc_squelch_gate #(
    .N (NUM_AUX)
  ) u_aux_gate (
    .clk          (ref_clk),
    .rst_n        (rst_n_q),
    .squelch_en   (aux_sq_q),
    .carries_clk  (aux_mode_q),
    .src_invalid  (inv_q),
    .out_enable_q (aux_enable_q)
  );

  // Divide values gathered in delay-bit order.
  assign ratio[DIV_PAIR01_BIT] = div_pair01_ratio;
  assign ratio[DIV_PAIR23_BIT] = div_pair23_ratio;
  assign ratio[DIV4_BIT]       = div4_ratio;
  assign ratio[DIV5_BIT]       = div5_ratio;
  assign ratio[DIV6_BIT]       = div6_ratio;
  assign ratio[DIV7_BIT]       = div7_ratio;

  // Margining is held off for small ratios, where the delay step would
  // swallow a whole output period and glitch the clock.
  for (genvar k = 0; k < NUM_DIV; k++) begin : g_margin
    assign over_min[k] = ratio[k] > DIV_MARGIN_MIN;
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        div_margin_active_q[k] <= 1'b0;
      end else begin
        div_margin_active_q[k] <= div_dly_q[k] && over_min[k];
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_q);

  // A write of a register followed at once by a read of it.
  sequence s_wr_chan;
    reg_wr && reg_addr == OFFS_CHAN_SQ;
  endsequence

  sequence s_rd_chan;
    reg_rd && reg_addr == OFFS_CHAN_SQ;
  endsequence

  sequence s_wr_aux;
    reg_wr && reg_addr == OFFS_AUX_SQ;
  endsequence

  sequence s_wr_div;
    reg_wr && reg_addr == OFFS_DIV_DLY;
  endsequence

  sequence s_rd_div;
    reg_rd && reg_addr == OFFS_DIV_DLY;
  endsequence

  // Source held invalid with no register writes long enough to pass
  // the synchroniser and the gating flop.
  sequence s_inv_held;
    (src_invalid && !reg_wr) [*4];
  endsequence

  AST_CHAN_SQUELCHED: assert property (
    inv_q |=> (chan_enable_q & $past(chan_sq_q)) == '0
  ) else $error("squelched channel still enabled on invalid source");

  AST_CHAN_FREE: assert property (
    1'b1 |=> &(chan_enable_q | $past(chan_sq_q))
  ) else $error("unsquelched channel was disabled");

  AST_CHAN_READBACK: assert property (
    s_wr_chan ##1 s_rd_chan |=> reg_rdata_q == $past(reg_wdata, 2)
  ) else $error("channel squelch readback mismatch");

  AST_AUX_SQUELCHED: assert property (
    inv_q |=> (aux_enable_q & $past(aux_sq_q & aux_mode_q)) == '0
  ) else $error("clocking aux pin not squelched");

  AST_AUX_STATUS_MODE: assert property (
    1'b1 |=> &(aux_enable_q | $past(aux_mode_q))
  ) else $error("aux pin in status mode was disabled");

  AST_AUX_FREE: assert property (
    1'b1 |=> &(aux_enable_q | $past(aux_sq_q))
  ) else $error("aux pin with squelch off was disabled");

  AST_AUX_FIELDS: assert property (
    s_wr_aux |=> aux_sq_q[AUX1_BIT] == $past(reg_wdata[AUX1_BIT])
             && aux_sq_q[AUX0_BIT] == $past(reg_wdata[AUX0_BIT])
  ) else $error("aux squelch bits misplaced");

  AST_MARGIN_MIN: assert property (
    1'b1 |=> (div_margin_active_q & ~$past(over_min)) == '0
  ) else $error("margining active at divide value of 8 or less");

  AST_MARGIN_DIV7: assert property (
    s_wr_div ##1 (div7_ratio > DIV_MARGIN_MIN)
      |=> div_margin_active_q[DIV7_BIT] == $past(reg_wdata[DIV7_BIT], 2)
  ) else $error("divider 7 margining does not follow its bit");

  AST_MARGIN_PAIR01: assert property (
    s_wr_div ##1 (div_pair01_ratio > DIV_MARGIN_MIN)
      |=> div_margin_active_q[DIV_PAIR01_BIT]
          == $past(reg_wdata[DIV_PAIR01_BIT], 2)
  ) else $error("pair 01 margining does not follow its bit");

  AST_RESERVED_ZERO: assert property (
    s_wr_div ##1 s_rd_div
      |=> reg_rdata_q == ($past(reg_wdata, 2) & MASK_DIV_DLY)
  ) else $error("reserved delay bits read back nonzero");

  AST_SHARED_INVALID: assert property (
    s_inv_held |=> (chan_enable_q & chan_sq_q) == '0
                && (aux_enable_q & aux_sq_q & aux_mode_q) == '0
  ) else $error("held invalid source did not squelch every output");

  // Reads of the aux register and of the two live-state registers.
  sequence s_rd_aux;
    reg_rd && reg_addr == OFFS_AUX_SQ;
  endsequence

  sequence s_rd_gate;
    reg_rd && reg_addr == OFFS_GATE_STATE;
  endsequence

  sequence s_rd_margin;
    reg_rd && reg_addr == OFFS_MARGIN_STATE;
  endsequence

  // Read data must not linger: a stale byte could pass for a fresh read.
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata_q == RDATA_IDLE
  ) else $error("read data did not return to idle");

  AST_UNMAPPED_READ: assert property (
    reg_rd && sel == OSMC_SEL_NONE |=> reg_rdata_q == RDATA_IDLE
  ) else $error("unmapped read returned nonzero data");

  // Writes land in the very next cycle.
  AST_CHAN_WRITE: assert property (
    s_wr_chan |=> chan_sq_q == $past(reg_wdata)
  ) else $error("channel squelch write did not land");

  AST_DIV_WRITE: assert property (
    s_wr_div |=> div_dly_q == $past(reg_wdata[NUM_DIV-1:0])
  ) else $error("delay write did not land or kept reserved bits");

  AST_AUX_RESERVED: assert property (
    s_wr_aux ##1 s_rd_aux
      |=> reg_rdata_q == ($past(reg_wdata, 2) & MASK_AUX_SQ)
  ) else $error("reserved aux squelch bits read back nonzero");

  AST_GATE_READBACK: assert property (
    s_rd_gate |=> reg_rdata_q == $past(chan_enable_q)
  ) else $error("channel enable state readback mismatch");

  AST_MARGIN_READBACK: assert property (
    s_rd_margin |=> reg_rdata_q[NUM_DIV-1:0] == $past(div_margin_active_q)
                 && reg_rdata_q[DATA_W-1:NUM_DIV] == '0
  ) else $error("margin state readback mismatch");

  // A valid source must leave every output running, whatever is set.
  AST_CHAN_RESTORE: assert property (
    !inv_q |=> &chan_enable_q
  ) else $error("channel stopped while the source is valid");

  AST_AUX_RESTORE: assert property (
    !inv_q |=> &aux_enable_q
  ) else $error("aux pin stopped while the source is valid");

  // Each delay bit must steer its own divider and no other.
  AST_MARGIN_DIV6: assert property (
    s_wr_div ##1 (div6_ratio > DIV_MARGIN_MIN)
      |=> div_margin_active_q[DIV6_BIT] == $past(reg_wdata[DIV6_BIT], 2)
  ) else $error("divider 6 margining does not follow its bit");

  AST_MARGIN_DIV5: assert property (
    s_wr_div ##1 (div5_ratio > DIV_MARGIN_MIN)
      |=> div_margin_active_q[DIV5_BIT] == $past(reg_wdata[DIV5_BIT], 2)
  ) else $error("divider 5 margining does not follow its bit");

  AST_MARGIN_DIV4: assert property (
    s_wr_div ##1 (div4_ratio > DIV_MARGIN_MIN)
      |=> div_margin_active_q[DIV4_BIT] == $past(reg_wdata[DIV4_BIT], 2)
  ) else $error("divider 4 margining does not follow its bit");

  AST_MARGIN_PAIR23: assert property (
    s_wr_div ##1 (div_pair23_ratio > DIV_MARGIN_MIN)
      |=> div_margin_active_q[DIV_PAIR23_BIT]
          == $past(reg_wdata[DIV_PAIR23_BIT], 2)
  ) else $error("pair 23 margining does not follow its bit");

endmodule

// file: osmc_clk_sink.sv
// Stand-in for the downstream parts that receive the generated clocks.
// Each one only notes whether its clock was running at the last edge.
module osmc_clk_sink
  import osmc_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic [NUM_CHAN-1:0]         chan_run,
  input  wire logic [NUM_AUX-1:0]          aux_run,
  output logic      [NUM_CHAN+NUM_AUX-1:0] live_q
);
  timeunit 1ns;
  timeprecision 1ps;

  // A receiver cannot tell a squelched output from a dead one, so it
  // records only presence; the sampled copy lags the enables by one edge.
  always_ff @(posedge ref_clk) begin
    live_q <= {aux_run, chan_run};
  end
endmodule

// file: tb.sv
module tb
  import osmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                ref_clk = 1'b0;
  logic                rst_b = 1'b0;
  logic [ADDR_W-1:0]   reg_addr = '0;
  logic [DATA_W-1:0]   reg_wdata = '0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [DATA_W-1:0]   reg_rdata_q;
  logic                src_invalid = 1'b0;
  logic                aux_pin0_clk_mode = 1'b0;
  logic                aux_pin1_clk_mode = 1'b0;
  logic [DIV_W-1:0]    ratio [NUM_DIV] = '{default: 8'h01};
  logic [NUM_CHAN-1:0] chan_enable_q;
  logic [NUM_AUX-1:0]  aux_enable_q;
  logic [NUM_DIV-1:0]  div_margin_active_q;
  logic [9:0]          live_q;
  logic [7:0]          sq, aq, dq, ec, ea;
  int                  miscompares = 0;
  int                  compares = 0;

  // Half period of 10 ns gives the 50 MHz reference.
  always #10 ref_clk = ~ref_clk;

  osmc_output_squelch_margin_ctrl osmc_output_squelch_margin_ctrl_inst (
    .ref_clk             (ref_clk),
    .rst_b               (rst_b),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata_q         (reg_rdata_q),
    .src_invalid         (src_invalid),
    .aux_pin0_clk_mode   (aux_pin0_clk_mode),
    .aux_pin1_clk_mode   (aux_pin1_clk_mode),
    .div_pair01_ratio    (ratio[0]),
    .div_pair23_ratio    (ratio[1]),
    .div4_ratio          (ratio[2]),
    .div5_ratio          (ratio[3]),
    .div6_ratio          (ratio[4]),
    .div7_ratio          (ratio[5]),
    .chan_enable_q       (chan_enable_q),
    .aux_enable_q        (aux_enable_q),
    .div_margin_active_q (div_margin_active_q)
  );

  osmc_clk_sink osmc_clk_sink_inst (
    .ref_clk  (ref_clk),
    .chan_run (chan_enable_q),
    .aux_run  (aux_enable_q),
    .live_q   (live_q)
  );

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle strobes; the release edge keeps back-to-back calls legal.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the read edge.
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask

  // Write then read one register with no gap between the two strobes.
  task automatic wr_rd(logic [7:0] a, logic [7:0] d, logic [7:0] exp);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge ref_clk);
    reg_rd    <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask

  // Margining needs both the delay bit and a divide value above eight.
  function automatic logic [7:0] exp_margin(logic [7:0] dly);
    logic [7:0] r;
    r = '0;
    for (int k = 0; k < NUM_DIV; k++) begin
      r[k] = dly[k] && (ratio[k] > DIV_MARGIN_MIN);
    end
    return r;
  endfunction

  // Cut a hang short; the full run needs about 22 us.
  initial begin
    #200us;
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(9));
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h16, 8'hff);
    rd(8'h17, 8'h02);
    rd(8'h18, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h20, 8'h00);
    rd(8'h16, 8'hff);
    wr(8'h17, 8'hfc);
    rd(8'h17, 8'h00);
    wr(8'h18, 8'hc0);
    rd(8'h18, 8'h00);
    for (int it = 0; it < 40; it++) begin
      sq = (it < 2) ? 8'hff : 8'($urandom);
      aq = (it < 2) ? 8'hff : 8'($urandom);
      dq = (it < 2) ? 8'hff : 8'($urandom);
      @(posedge ref_clk);
      src_invalid       <= (it < 2) ? 1'b1 : 1'($urandom);
      aux_pin0_clk_mode <= (it == 1) ? 1'b0 : 1'($urandom);
      aux_pin1_clk_mode <= (it == 0) ? 1'b1 : 1'($urandom);
      for (int k = 0; k < NUM_DIV; k++) begin
        ratio[k] <= (it == 0) ? 8'h08 : (it == 1) ? 8'h09 : 8'($urandom);
      end
      wr_rd(8'h16, sq, sq);
      wr_rd(8'h17, aq, aq & MASK_AUX_SQ);
      wr_rd(8'h18, dq, dq & MASK_DIV_DLY);
      // Enables settle within three edges of any input change.
      repeat (6) @(posedge ref_clk);
      #1;
      ec = src_invalid ? ~sq : 8'hff;
      chk(chan_enable_q, ec);
      ea = {6'h00, src_invalid ? ~(aq[1:0] &
           {aux_pin1_clk_mode, aux_pin0_clk_mode}) : 2'b11};
      chk({6'h00, aux_enable_q}, ea);
      chk({2'b00, div_margin_active_q}, exp_margin(dq));
      chk(live_q[7:0], ec);
      chk({6'h00, live_q[9:8]}, ea);
      rd(8'h16, sq);
      rd(8'h17, aq & MASK_AUX_SQ);
      rd(8'h18, dq & MASK_DIV_DLY);
      rd(8'h30, ec);
      rd(8'h31, exp_margin(dq));
    end
    // A second reset mid-run must bring back every reset value.
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(chan_enable_q, 8'hff);
    chk({6'h00, aux_enable_q}, 8'h03);
    chk({2'b00, div_margin_active_q}, 8'h00);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h16, 8'hff);
    rd(8'h17, 8'h02);
    rd(8'h18, 8'h00);
    end_of_test();
  end
endmodule
